/* File: core/uart_pkg.sv */
// constants, types and register map of the queued serial port
// assumes an APB3 master with 32-bit data and a 200 MHz clk
// Functional notes
// [RULE1] separate fifteen-byte transmit and receive queues, own counts and thresholds
// [RULE2] bit rate comes from a dedicated sixteen-bit clock divisor
// [RULE3] port enable gates both sending queued bytes and storing received ones
// [RULE4] stop-count bit set gives two stop bits, clear gives one
// [RULE5] word length field picks five, six, seven or eight data bits
// [RULE6] break bit holds the serial output low until cleared
// [RULE7] parity sense: zero even, one odd
// [RULE8] parity enable written; reading that bit gives head byte parity error
// [RULE9] forced-parity bit sends the parity bit as constant one
// [RULE10] status register reads receive count and transmit count, four bits each
// [RULE11] receive threshold 0..14; available flag when count exceeds it
// [RULE12] transmit threshold 1..15; room flag when count below it
// [RULE13] divisor low twelve bits zero and disabled empties queues, clears flags, counter; code clears only the overflow and underflow flags
// [RULE14] master interrupt enable, zero after reset, gates the interrupt request
// [RULE15] room flag follows its condition; writing one enables its interrupt
// [RULE16] available flag also set after idle longer than threshold times sixteen bits
// [RULE17] writing zero clears available flag when not above threshold, disables interrupt
// [RULE18] sticky overflow and underflow flags; cleared by zero write or queue reset
// [RULE19] sticky framing error on bad stop bit, cleared only by zero write
// [RULE20] sticky transmit-complete flag once queue drained; zero write clears it
// [RULE21] bit rate equals clock divided by divisor; zero divisor stops the port
// [RULE22] data port read pops receive queue, write pushes transmit queue
// [RULE23] frame: low start, data lsb first, optional parity, high stop bits
package uart_pkg;
  localparam int FIFO_DEPTH = 15;
  localparam int CNT_W = 4;
  localparam int DIV_W = 16;
  localparam int DIV_CLR_W = 12;
  localparam int IDLE_SHIFT = 4;
  localparam logic [9:0] IDX_STATUS = 10'h0A5;
  localparam logic [9:0] IDX_DATA = 10'h0A6;
  localparam logic [9:0] IDX_FLAGS = 10'h0A7;
  localparam logic [9:0] IDX_LINE = 10'h0C2;
  localparam logic [9:0] IDX_DIV_LO = 10'h0A8;
  localparam logic [9:0] IDX_DIV_HI = 10'h0A9;
  localparam logic [9:0] IDX_FRAMES = 10'h0AA;
  localparam logic [3:0] RX_THR_RSVD = 4'hF;
  localparam logic [3:0] TX_THR_RSVD = 4'h0;
  localparam logic [3:0] THR_RST = 4'h0;
  localparam logic [15:0] DIV_RST = 16'h0000;

  typedef struct packed {
    logic en;
    logic sb;
    logic [1:0] wls;
    logic brk;
    logic op;
    logic pe;
    logic sp;
  } line_cfg_s;

  typedef struct packed {
    logic port_irq_master_enable;
    logic tx_room_flag;
    logic rx_available_flag;
    logic rx_overflow_flag;
    logic rx_underflow_flag;
    logic tx_overflow_flag;
    logic framing_error_flag;
    logic ti;
  } flag_s;

  localparam line_cfg_s LINE_RST = 8'h00;
  localparam flag_s FLAG_RST = 8'h00;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_START = 3'b001,
    PH_DATA = 3'b010,
    PH_PAR = 3'b011,
    PH_STOP = 3'b100
  } phase_e;
endpackage

/* File: core/bit_timer.sv */
// bit period tick generator, one tick every divisor clocks
// assumes divisor is stable during a character
module bit_timer
  import uart_pkg::*;
#(
  parameter int W = DIV_W
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic restart,
  input wire logic half,
  input wire logic [W-1:0] divisor,
  output logic tick
);
  if (W < 2) begin : g_chk
    $error("bit_timer needs W of at least 2");
  end

  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } tmr_s;

  tmr_s st;
  tmr_s next_st;

  // zero divisor never ticks, so the port simply stalls
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (restart) begin
      // tick shows a clock after the reload, so a fresh start loads one less
      next_st.cnt = half ? {1'b0, divisor[W-1:1]} : divisor - 1'b1;
    end else if (divisor != '0) begin // [RULE21]
      if (st.cnt <= 1) begin
        next_st.cnt = divisor;
        next_st.tick = 1'b1;
      end else begin
        next_st.cnt = st.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
endmodule

/* File: core/queue_fifo.sv */
// circular queue of W-bit entries with level count
// assumes push to a full queue and pop of an empty one are dropped
module queue_fifo
  import uart_pkg::*;
#(
  parameter int W = 8,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int CW = CNT_W
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic push,
  input wire logic [W-1:0] pushData,
  input wire logic pop,
  output logic [W-1:0] headData,
  output logic [CW-1:0] count,
  output logic full,
  output logic empty
);
  if (DEPTH < 2 || CW != $clog2(DEPTH + 1)) begin : g_chk
    $error("queue_fifo depth and count width disagree");
  end

  typedef struct packed {
    logic [CW-1:0] rd;
    logic [CW-1:0] wr;
    logic [CW-1:0] cnt;
  } ptr_s;

  ptr_s st;
  ptr_s next_st;
  logic [W-1:0] mem [DEPTH];
  logic doPush;
  logic doPop;

  function automatic logic [CW-1:0] stepPtr(input logic [CW-1:0] p);
    return (p == CW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign full = (st.cnt == CW'(DEPTH));
  assign empty = (st.cnt == '0);
  assign doPush = push && !full && !clear;
  assign doPop = pop && !empty && !clear;

  always_comb begin
    next_st = st;
    if (clear) begin
      next_st = '0;
    end else begin
      if (doPush) begin
        next_st.wr = stepPtr(st.wr);
      end
      if (doPop) begin
        next_st.rd = stepPtr(st.rd);
      end
      if (doPush && !doPop) begin
        next_st.cnt = st.cnt + 1'b1;
      end else if (doPop && !doPush) begin
        next_st.cnt = st.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // storage carries no reset, only pointers do
  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[st.wr] <= pushData;
    end
  end

  assign headData = mem[st.rd];
  assign count = st.cnt;
endmodule

/* File: core/fifo_uart_with_thresholds.sv */
// queued asynchronous serial port with APB register access
// assumes rxd is asynchronous to clk; APB3 master, zero wait after setup
//
// Design decision made here: register access over APB.
module fifo_uart_with_thresholds
  import uart_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  output logic txd,
  output logic irq
);
  if (DEPTH < 2 || DEPTH > 15) begin : g_chk
    $error("queue depth must fit a four-bit level field");
  end

  typedef struct packed {
    line_cfg_s cfg;
    logic [DIV_W-1:0] div;
    logic [3:0] rxThr;
    logic [3:0] txThr;
    flag_s flg;
    flag_s ena;
    phase_e txSt;
    logic [7:0] txSh;
    logic [3:0] txBits;
    logic txPar;
    phase_e rxSt;
    logic [7:0] rxSh;
    logic [3:0] rxBits;
    logic rxPar;
    logic [7:0] idleBits;
    logic [15:0] frames;
    logic [1:0] rxSync;
    logic rxPrev;
    logic txd, irq, pready, pslverr;
    logic [31:0] prdata;
  } st_s;

  st_s st;
  st_s next_st;

  function automatic logic [3:0] dataBits(input logic [1:0] wls);
    return 4'd5 + {2'b00, wls};
  endfunction

  function automatic logic parityOf(input logic [7:0] d, input logic [1:0] wls);
    logic [7:0] m;
    m = 8'hFF >> (4'd8 - dataBits(wls));
    return ^(d & m);
  endfunction

  logic [9:0] idx;
  logic setup, acc, flagWr;
  flag_s fw;
  logic qReset, rxS;
  logic [3:0] nBits;
  logic txPush, txPop;
  logic [7:0] txHead;
  logic [CNT_W-1:0] txCount, rxCount;
  logic txFull, txEmpty;
  logic rxPush, rxPop;
  logic [8:0] rxPushData, rxHead;
  logic rxFull, rxEmpty;
  logic txTick, rxTick;
  logic txRestart, rxRestart, rxHalf;
  logic [7:0] rxData;
  logic rxAbove, rxTimeout;
  logic [31:0] rdVal;
  logic rdMapped;

  assign idx = paddr[11:2];
  assign setup = psel && !penable;
  assign acc = psel && penable && st.pready;
  assign flagWr = acc && pwrite && (idx == IDX_FLAGS);
  assign fw = flag_s'(pwdata[7:0]);
  assign qReset = (st.div[DIV_CLR_W-1:0] == '0) && !st.cfg.en; // [RULE13]
  assign nBits = dataBits(st.cfg.wls); // [RULE5]
  assign rxS = st.rxSync[1];
  assign txPush = acc && pwrite && (idx == IDX_DATA); // [RULE22]
  assign rxPop = acc && !pwrite && (idx == IDX_DATA); // [RULE22]
  assign rxData = st.rxSh >> (4'd8 - nBits);
  assign rxAbove = rxCount > st.rxThr; // [RULE11]
  assign rxTimeout = (rxCount != '0) && !rxAbove
    && (st.idleBits > (8'(st.rxThr) << IDLE_SHIFT)); // [RULE16]

  queue_fifo #(.W(8), .DEPTH(DEPTH), .CW(CNT_W)) u_txq ( // [RULE1]
    .clk(clk),
    .reset_n(reset_n),
    .clear(qReset),
    .push(txPush),
    .pushData(pwdata[7:0]),
    .pop(txPop),
    .headData(txHead),
    .count(txCount),
    .full(txFull),
    .empty(txEmpty)
  );

  queue_fifo #(.W(9), .DEPTH(DEPTH), .CW(CNT_W)) u_rxq ( // [RULE1]
    .clk(clk),
    .reset_n(reset_n),
    .clear(qReset),
    .push(rxPush),
    .pushData(rxPushData),
    .pop(rxPop),
    .headData(rxHead),
    .count(rxCount),
    .full(rxFull),
    .empty(rxEmpty)
  );

  bit_timer #(.W(DIV_W)) u_txtmr ( // [RULE2]
    .clk(clk),
    .reset_n(reset_n),
    .restart(txRestart),
    .half(1'b0),
    .divisor(st.div),
    .tick(txTick)
  );

  // receive timer free-runs while idle so idle time can be counted
  bit_timer #(.W(DIV_W)) u_rxtmr ( // [RULE2]
    .clk(clk),
    .reset_n(reset_n),
    .restart(rxRestart),
    .half(rxHalf),
    .divisor(st.div),
    .tick(rxTick)
  );

  always_comb begin
    rdMapped = 1'b1;
    rdVal = '0;
    case (idx)
      IDX_STATUS: rdVal[7:0] = {rxCount, txCount}; // [RULE10]
      IDX_DATA: rdVal[7:0] = rxHead[7:0];
      IDX_FLAGS: rdVal[7:0] = {st.ena.port_irq_master_enable, st.flg.tx_room_flag, st.flg.rx_available_flag, st.flg.rx_overflow_flag,
                               st.flg.rx_underflow_flag, st.flg.tx_overflow_flag, st.flg.framing_error_flag, st.flg.ti};
      IDX_LINE: rdVal[7:0] = {st.cfg.en, st.cfg.sb, st.cfg.wls, st.cfg.brk,
                              st.cfg.op, rxHead[8] && !rxEmpty, st.cfg.sp}; // [RULE8]
      IDX_DIV_LO: rdVal[7:0] = st.div[7:0];
      IDX_DIV_HI: rdVal[7:0] = st.div[15:8];
      IDX_FRAMES: rdVal[15:0] = st.frames;
      default: rdMapped = 1'b0;
    endcase
  end

  always_comb begin
    next_st = st;
    txPop = 1'b0;
    txRestart = (st.txSt == PH_IDLE);
    rxRestart = 1'b0;
    rxHalf = 1'b0;
    rxPush = 1'b0;
    rxPushData = '0;

    // bus side: answer is prepared in setup, acted on in access
    next_st.pready = setup;
    next_st.pslverr = setup && !rdMapped;
    if (setup) begin
      next_st.prdata = pwrite ? 32'h0000_0000 : rdVal;
    end
    if (acc && pwrite) begin
      case (idx)
        IDX_LINE: next_st.cfg = line_cfg_s'(pwdata[7:0]);
        IDX_DIV_LO: next_st.div[7:0] = pwdata[7:0];
        IDX_DIV_HI: next_st.div[15:8] = pwdata[7:0];
        IDX_STATUS: begin
          // reserved threshold codes are ignored, old value kept
          if (pwdata[7:4] != RX_THR_RSVD) begin
            next_st.rxThr = pwdata[7:4]; // [RULE11]
          end
          if (pwdata[3:0] != TX_THR_RSVD) begin
            next_st.txThr = pwdata[3:0]; // [RULE12]
          end
        end
        IDX_FLAGS: next_st.ena = fw; // [RULE14]
        default: next_st.ena = st.ena;
      endcase
    end

    next_st.rxSync = {st.rxSync[0], rxd};
    next_st.rxPrev = rxS;

    case (st.txSt)
      PH_IDLE: begin
        if (st.cfg.en && !txEmpty && !qReset) begin // [RULE3]
          txPop = 1'b1;
          next_st.txSh = txHead;
          next_st.txBits = '0;
          next_st.txPar = st.cfg.sp ? 1'b1 : parityOf(txHead, st.cfg.wls) ^ st.cfg.op; // [RULE7] [RULE9]
          next_st.txSt = PH_START;
        end
      end
      PH_START: begin
        if (txTick) begin
          next_st.txSt = PH_DATA;
        end
      end
      PH_DATA: begin
        if (txTick) begin
          next_st.txSh = {1'b0, st.txSh[7:1]}; // [RULE23]
          next_st.txBits = st.txBits + 1'b1;
          if (st.txBits == nBits - 4'd1) begin // [RULE5]
            next_st.txBits = '0;
            next_st.txSt = st.cfg.pe ? PH_PAR : PH_STOP; // [RULE8]
          end
        end
      end
      PH_PAR: begin
        if (txTick) begin
          next_st.txSt = PH_STOP;
        end
      end
      PH_STOP: begin
        if (txTick) begin
          next_st.txBits = st.txBits + 1'b1;
          if (st.txBits == {3'b000, st.cfg.sb}) begin // [RULE4]
            next_st.txSt = PH_IDLE;
          end
        end
      end
      default: next_st.txSt = PH_IDLE;
    endcase

    case (st.rxSt)
      PH_IDLE: begin
        if (st.cfg.en && !qReset && st.rxPrev && !rxS) begin // [RULE3]
          rxRestart = 1'b1;
          rxHalf = 1'b1;
          next_st.rxSt = PH_START;
        end
      end
      PH_START: begin
        if (rxTick) begin
          next_st.rxBits = '0;
          next_st.rxSt = rxS ? PH_IDLE : PH_DATA; // [RULE23]
        end
      end
      PH_DATA: begin
        if (rxTick) begin
          next_st.rxSh = {rxS, st.rxSh[7:1]};
          next_st.rxBits = st.rxBits + 1'b1;
          if (st.rxBits == nBits - 4'd1) begin
            next_st.rxSt = st.cfg.pe ? PH_PAR : PH_STOP;
          end
        end
      end
      PH_PAR: begin
        if (rxTick) begin
          next_st.rxPar = rxS;
          next_st.rxSt = PH_STOP;
        end
      end
      PH_STOP: begin
        if (rxTick) begin
          rxPush = !qReset;
          rxPushData[7:0] = rxData;
          rxPushData[8] = st.cfg.pe && (st.cfg.sp ? !st.rxPar
            : (st.rxPar != (parityOf(rxData, st.cfg.wls) ^ st.cfg.op))); // [RULE8]
          next_st.rxSt = PH_IDLE;
        end
      end
      default: next_st.rxSt = PH_IDLE;
    endcase

    if (st.rxSt != PH_IDLE || !rxS) begin
      next_st.idleBits = '0;
    end else if (rxTick && st.idleBits != 8'hFF) begin
      next_st.idleBits = st.idleBits + 1'b1;
    end
    if (qReset) begin
      next_st.frames = '0; // [RULE13]
    end else if (rxTick) begin
      next_st.frames = st.frames + 1'b1;
    end

    // sticky flags: a set in the clearing cycle wins
    next_st.flg.port_irq_master_enable = 1'b0;
    next_st.flg.tx_room_flag = txCount < st.txThr; // [RULE12] [RULE15]
    next_st.flg.rx_available_flag = rxAbove || rxTimeout
      || (st.flg.rx_available_flag && !(flagWr && !fw.rx_available_flag && !rxAbove)); // [RULE17]
    next_st.flg.rx_overflow_flag = (rxPush && rxFull)
      || (st.flg.rx_overflow_flag && !(flagWr && !fw.rx_overflow_flag) && !qReset); // [RULE18]
    next_st.flg.rx_underflow_flag = (rxPop && rxEmpty && !qReset)
      || (st.flg.rx_underflow_flag && !(flagWr && !fw.rx_underflow_flag) && !qReset); // [RULE18]
    next_st.flg.tx_overflow_flag = (txPush && txFull && !qReset)
      || (st.flg.tx_overflow_flag && !(flagWr && !fw.tx_overflow_flag) && !qReset); // [RULE18]
    next_st.flg.framing_error_flag = (st.rxSt == PH_STOP && rxTick && !rxS)
      || (st.flg.framing_error_flag && !(flagWr && !fw.framing_error_flag)); // [RULE19]
    next_st.flg.ti = (st.txSt == PH_STOP && next_st.txSt == PH_IDLE && txEmpty)
      || (st.flg.ti && !(flagWr && !fw.ti)); // [RULE20]

    next_st.irq = next_st.ena.port_irq_master_enable
      && ((next_st.flg[6:0] & next_st.ena[6:0]) != 7'h00); // [RULE14]

    if (next_st.cfg.brk) begin
      next_st.txd = 1'b0; // [RULE6]
    end else begin
      case (next_st.txSt)
        PH_START: next_st.txd = 1'b0;
        PH_DATA: next_st.txd = next_st.txSh[0];
        PH_PAR: next_st.txd = next_st.txPar;
        default: next_st.txd = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.cfg <= LINE_RST;
      st.div <= DIV_RST;
      st.rxThr <= THR_RST;
      st.txThr <= THR_RST;
      st.flg <= FLAG_RST;
      st.ena <= FLAG_RST;
      st.rxSync <= 2'b11;
      st.rxPrev <= 1'b1;
      st.txd <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign txd = st.txd;
  assign irq = st.irq;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_break_low: assert property (st.cfg.brk |-> !txd) // [RULE6]
    else $error("break set but line not low");
  a_start_low: assert property ((st.txSt == PH_START && !st.cfg.brk) |-> !txd) // [RULE23]
    else $error("start bit not low");
  a_room_level: assert property (1'b1 |=> st.flg.tx_room_flag == $past(txCount < st.txThr)) // [RULE15]
    else $error("room flag does not follow level");
  a_queue_reset: assert property (qReset |=> (rxCount == '0 && txCount == '0 // [RULE13]
    && !st.flg.rx_overflow_flag && !st.flg.rx_underflow_flag && !st.flg.tx_overflow_flag))
    else $error("queue reset left state behind");
  a_pop_count: assert property ((rxPop && !rxEmpty && !rxPush && !qReset) // [RULE22]
    |=> rxCount == $past(rxCount) - 4'd1)
    else $error("data read did not pop");
  a_irq_gate: assert property (!st.ena.port_irq_master_enable |-> !st.irq) // [RULE14]
    else $error("irq without master enable");
  a_framing_error_flag_hold: assert property ((st.flg.framing_error_flag && !(flagWr && !fw.framing_error_flag)) |=> st.flg.framing_error_flag) // [RULE19]
    else $error("framing flag lost");
  a_tfo_set: assert property ((txPush && txFull && !qReset) |=> st.flg.tx_overflow_flag) // [RULE18]
    else $error("tx overflow not flagged");
  a_disabled_idle: assert property ((!st.cfg.en && st.txSt == PH_IDLE) // [RULE3]
    |=> st.txSt == PH_IDLE)
    else $error("transmit started while disabled");
endmodule

/* File: testbench/serial_node.sv */
// remote serial node: decodes frames seen on txd and sends frames on rxd
// assumes div matches the divisor and the bench sets nb, np and ns to match the line setup
module serial_node (
  input wire logic clk,
  input wire logic txd,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  int div = 8;
  int nb = 8;
  int np = 0;
  int ns = 1;
  logic [9:0] got[$];

  // idle line rests high, as a released line with pull-up would
  initial rxd = 1'b1;

  // start low, data lsb first, optional parity, stop level given
  task automatic send(input logic [7:0] d, input logic pb, input logic sb);
    rxd <= 1'b0;
    repeat (div) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      rxd <= d[i];
      repeat (div) @(posedge clk);
    end
    if (np != 0) begin
      rxd <= pb;
      repeat (div) @(posedge clk);
    end
    rxd <= sb;
    repeat (div) @(posedge clk);
    rxd <= 1'b1;
    repeat (div) @(posedge clk);
  endtask

  // mid-bit sampling; every stop bit must be high, so a short stop shows
  always begin : decode
    logic [7:0] d;
    logic p;
    logic ok;
    @(negedge txd);
    d = 8'h00;
    p = 1'b0;
    ok = 1'b1;
    repeat (div / 2) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      repeat (div) @(posedge clk);
      d[i] = txd;
    end
    if (np != 0) begin
      repeat (div) @(posedge clk);
      p = txd;
    end
    for (int i = 0; i < ns; i++) begin
      repeat (div) @(posedge clk);
      ok = ok & txd;
    end
    got.push_back({ok, p, d});
  end
endmodule

/* File: testbench/fifo_uart_with_thresholds_bench.sv */
// self-checking bench for the queued serial port
// assumes serial_node on txd/rxd and the register indexes of uart_pkg
module fifo_uart_with_thresholds_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import uart_pkg::*;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, rxd, txd, irq, ev;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  int num_errors = 0;
  int checked = 0;

  fifo_uart_with_thresholds dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));
  serial_node node (.clk(clk), .txd(txd), .rxd(rxd));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // one idle cycle after each transfer keeps every strobe to one assignment per step
  task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {a, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic poll(input int b);
    int k;
    k = 0;
    do begin
      apb(1'b0, IDX_FLAGS, 8'h00);
      repeat (20) @(posedge clk);
      k++;
    end while (rv[b] !== 1'b1 && k < 60);
  endtask

  task automatic t_regs;
    apb(1'b0, IDX_STATUS, 8'h00);
    chk("status reset", 32'h0, rv);
    chk("mapped no error", 32'h0, {31'h0, ev});
    apb(1'b0, IDX_FLAGS, 8'h00);
    chk("flags reset", 32'h0, rv);
    apb(1'b0, IDX_LINE, 8'h00);
    chk("line reset", 32'h0, rv);
    apb(1'b0, 10'h3FF, 8'h00);
    chk("unmapped error", 32'h1, {31'h0, ev});
    chk("unmapped data", 32'h0, rv);
    chk("idle txd", 32'h1, {31'h0, txd});
  endtask

  task automatic t_tx;
    logic [7:0] cfg, e;
    logic [1:0] w;
    apb(1'b1, IDX_DIV_LO, 8'h08);
    apb(1'b1, IDX_DIV_HI, 8'h00);
    for (int c = 0; c < 6; c++) begin
      w = c[1:0];
      cfg = {1'b1, c[0], w, 1'b0, c[1], 1'b1, c == 5};
      node.nb = 5 + w;
      node.np = 1;
      node.ns = 1 + c[0];
      apb(1'b1, IDX_LINE, cfg);
      apb(1'b1, IDX_DATA, 8'hB6);
      apb(1'b1, IDX_DATA, 8'h4B);
      for (int k = 0; k < 4000 && node.got.size() < 2; k++) @(posedge clk);
      chk("frames seen", 32'h2, node.got.size());
      for (int k = 0; k < 2 && k < node.got.size(); k++) begin
        e = (k == 0 ? 8'hB6 : 8'h4B) & (8'hFF >> (3 - w));
        chk("tx data", e, node.got[k][7:0]);
        chk("tx parity", c == 5 ? 1'b1 : ^e ^ c[1], node.got[k][8]);
        chk("tx stop", 32'h1, node.got[k][9]);
      end
      node.got.delete();
      poll(0);
      chk("tx complete", 32'h1, rv[0]);
      apb(1'b1, IDX_FLAGS, 8'h00);
      apb(1'b0, IDX_FLAGS, 8'h00);
      chk("tx complete clear", 32'h0, rv[0]);
    end
  endtask

  task automatic t_break;
    int lows;
    lows = 0;
    apb(1'b1, IDX_LINE, 8'hB8);
    for (int k = 0; k < 100; k++) begin
      @(posedge clk);
      lows += (txd === 1'b0);
    end
    chk("break low", 32'd100, lows);
    apb(1'b1, IDX_LINE, 8'hB0);
    repeat (3) @(posedge clk);
    chk("break end", 32'h1, {31'h0, txd});
    // let the node finish decoding the break as a broken frame
    repeat (100) @(posedge clk);
    node.got.delete();
  endtask

  task automatic t_rx;
    apb(1'b1, IDX_LINE, 8'hB2);
    node.nb = 8;
    node.np = 1;
    apb(1'b1, IDX_STATUS, 8'h21);
    apb(1'b1, IDX_FLAGS, 8'hA0);
    node.send(8'h11, 1'b0, 1'b1);
    node.send(8'h22, 1'b1, 1'b1);
    apb(1'b0, IDX_STATUS, 8'h00);
    chk("rx count", 32'h20, rv);
    chk("irq at threshold", 32'h0, {31'h0, irq});
    node.send(8'h33, 1'b0, 1'b1);
    apb(1'b0, IDX_FLAGS, 8'h00);
    chk("rda above", 32'h1, rv[5]);
    chk("irq rda", 32'h1, {31'h0, irq});
    apb(1'b0, IDX_DATA, 8'h00);
    chk("rx first", 32'h11, rv);
    apb(1'b0, IDX_LINE, 8'h00);
    chk("head parity error", 32'h1, rv[1]);
    apb(1'b0, IDX_DATA, 8'h00);
    chk("rx second", 32'h22, rv);
    apb(1'b0, IDX_DATA, 8'h00);
    chk("rx third", 32'h33, rv);
    apb(1'b1, IDX_FLAGS, 8'h80);
    apb(1'b0, IDX_FLAGS, 8'h00);
    chk("rda cleared", 32'h0, rv[5]);
    chk("irq cleared", 32'h0, {31'h0, irq});
    apb(1'b0, IDX_DATA, 8'h00);
    apb(1'b0, IDX_FLAGS, 8'h00);
    chk("underflow", 32'h1, rv[3]);
    node.send(8'h44, 1'b0, 1'b0);
    apb(1'b0, IDX_FLAGS, 8'h00);
    chk("framing error", 32'h1, rv[1]);
    chk("rda not yet", 32'h0, rv[5]);
    poll(5);
    chk("rda on idle", 32'h1, rv[5]);
    apb(1'b0, IDX_DATA, 8'h00);
    chk("rx fourth", 32'h44, rv);
    apb(1'b1, IDX_FLAGS, 8'h00);
    apb(1'b0, IDX_FLAGS, 8'h00);
    chk("flags cleared", 32'h40, rv);
    // odd parity and seven data bits on the receive side
    apb(1'b1, IDX_LINE, 8'hA6);
    node.nb = 7;
    node.send(8'h35, 1'b1, 1'b1);
    node.nb = 8;
    apb(1'b0, IDX_LINE, 8'h00);
    chk("rx odd parity", 32'h0, rv[1]);
    apb(1'b0, IDX_DATA, 8'h00);
    chk("rx seven bits", 32'h35, rv);
  endtask

  task automatic t_queues;
    apb(1'b1, IDX_LINE, 8'h30);
    apb(1'b1, IDX_STATUS, 8'h2F);
    apb(1'b1, IDX_STATUS, 8'hF0);
    for (int k = 0; k < 16; k++) apb(1'b1, IDX_DATA, k[7:0]);
    apb(1'b0, IDX_STATUS, 8'h00);
    chk("tx full", 32'h0F, rv);
    apb(1'b0, IDX_FLAGS, 8'h00);
    chk("tx overflow", 32'h1, rv[2]);
    chk("tra at full", 32'h0, rv[6]);
    node.np = 0;
    node.send(8'h55, 1'b0, 1'b1);
    apb(1'b0, IDX_STATUS, 8'h00);
    chk("disabled rx", 32'h0F, rv);
    // zero divisor with port off empties both queues
    apb(1'b1, IDX_DIV_LO, 8'h00);
    apb(1'b0, IDX_STATUS, 8'h00);
    chk("queue reset", 32'h0, rv);
    apb(1'b0, IDX_FLAGS, 8'h00);
    chk("flags after reset", 32'h10, rv[6:2]);
    apb(1'b0, IDX_FRAMES, 8'h00);
    chk("frame counter", 32'h0, rv);
    apb(1'b1, IDX_DIV_LO, 8'h08);
    apb(1'b1, IDX_LINE, 8'hB0);
    for (int k = 0; k < 16; k++) node.send(k[7:0], 1'b0, 1'b1);
    apb(1'b0, IDX_STATUS, 8'h00);
    chk("rx full", 32'hF0, rv);
    apb(1'b0, IDX_FLAGS, 8'h00);
    chk("rx overflow", 32'h1, rv[4]);
    apb(1'b1, IDX_FLAGS, 8'h00);
    apb(1'b0, IDX_FLAGS, 8'h00);
    chk("rx overflow clear", 32'h0, rv[4]);
    apb(1'b0, IDX_DATA, 8'h00);
    chk("rx head kept", 32'h00, rv);
  endtask

  task automatic tally_and_finish;
    if (num_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_tx();
    t_break();
    t_rx();
    t_queues();
    tally_and_finish();
  end

  // whole run needs well under this many cycles
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end
endmodule
